// ### rtl/cpl_sideband_pkg.sv
package cpl_sideband_pkg;

  // ==========================================================================
  // Stream geometry
  localparam int DATA_W  = 256;
  localparam int LANES   = 32;
  localparam int DWORDS  = 8;
  localparam int CHUNK_W = 128;
  localparam int CHUNK_B = 16;
  localparam int HALF_DW = 4;

  // ==========================================================================
  // Sideband word layout, bit positions
  localparam int SB_BYTE_EN_LSB = 0;
  localparam int SB_SOF0_BIT    = 32;
  localparam int SB_SOF1_BIT    = 33;
  localparam int SB_EOF0_LSB    = 34;
  localparam int SB_EOF1_LSB    = 38;
  localparam int SB_ABORT_BIT   = 42;
  localparam int SB_PARITY_LSB  = 43;
  localparam int SB_W           = 75;

  // ==========================================================================
  // Data path width codes and lane masks
  localparam logic [1:0]  WIDTH_64     = 2'h0;
  localparam logic [1:0]  WIDTH_128    = 2'h1;
  localparam logic [1:0]  WIDTH_256    = 2'h2;
  localparam logic [31:0] LANE_MASK_64  = 32'h0000_00FF;
  localparam logic [31:0] LANE_MASK_128 = 32'h0000_FFFF;
  localparam logic [31:0] LANE_MASK_256 = 32'hFFFF_FFFF;
  localparam logic [7:0]  KEEP_MASK_64  = 8'h03;
  localparam logic [7:0]  KEEP_MASK_128 = 8'h0F;
  localparam logic [7:0]  KEEP_MASK_256 = 8'hFF;

  // ==========================================================================
  // Register map (byte addresses) and control fields
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam logic [3:0]  REG_PKT_CNT   = 4'h8;
  localparam logic [3:0]  REG_ABORT_CNT = 4'hC;
  localparam int          CTRL_WIDTH_LSB   = 0;
  localparam int          CTRL_STRADDLE_BIT = 2;
  localparam int          CTRL_ENDPOINT_BIT = 3;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_000A;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ==========================================================================
  // Upstream chunk: one 128-bit piece of a completion
  typedef struct packed {
    logic [127:0] data;
    logic [2:0]   dw_cnt;    // Valid dwords from lane 0, 1..4
    logic         sop;
    logic         eop;
    logic         pl_en;     // Chunk holds payload bytes
    logic [3:0]   pl_first;  // First payload byte in chunk
    logic [3:0]   pl_last;   // Last payload byte in chunk
    logic         err;       // Uncorrectable buffer read error
  } chunk_t;

  // Sideband word, most significant field first
  typedef struct packed {
    logic [31:0] parity;
    logic        abort;
    logic [3:0]  second_end_field;
    logic [3:0]  first_end_field;
    logic        second_start_flag;
    logic        first_start_flag;
    logic [31:0] byte_en;
  } sideband_t;

endpackage

// ### rtl/odd_parity_lanes.sv
`timescale 1ns/10ps

// ============================================================================
// Per-byte odd parity with lane enables
module odd_parity_lanes #(
  parameter int LANES = 32
) (
  input  wire logic [LANES*8-1:0] i_data,
  input  wire logic [LANES-1:0]   i_lane_en,
  output logic      [LANES-1:0]   o_parity
);

  // Parity bit makes byte plus bit odd; disabled lanes read zero
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      o_parity[i] = i_lane_en[i] & ~(^i_data[i*8 +: 8]);
    end
  end

endmodule

// ### rtl/completion_sideband_framer.sv
`timescale 1ns/10ps

// Behaviour
// RULE_01 - Byte flag only for payload bytes
// RULE_02 - Payload flags form one contiguous run
// RULE_03 - Upper flags zero on narrow paths
// RULE_04 - Zero-length read completion still flags byte
// RULE_05 - Narrow modes: one start, second flag zero
// RULE_06 - Straddle: first start lane 0 or 16
// RULE_07 - Second start only after lower-half end
// RULE_08 - First end bit plus last dword offset
// RULE_09 - Second end offset only 6 or 7; code gives 3 plus dword count, 4 to 7
// RULE_10 - Second end implies first end, second start
// RULE_11 - End fields reserved outside 256 straddle
// RULE_12 - Abort on final beat after buffer error
// RULE_13 - Receiver drops whole aborted packet
// RULE_14 - No abort without payload; last beat only
// RULE_15 - No second start in aborted beat
// RULE_16 - Endpoint reports aborting read error upstream
// RULE_17 - Parity bit is odd parity per byte
// RULE_18 - Unused parity bits zero on narrow paths
// RULE_19 - Two completions share beat only in straddle
// RULE_20 - Straddle holds all keep bits high
// RULE_21 - Beat moves on valid and ready; held
// RULE_22 - Reserved fields zero when not straddling
module completion_sideband_framer
  import cpl_sideband_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire chunk_t      i_chunk,
  input  wire logic        i_chunk_valid,
  output logic             o_chunk_ready,
  output logic [255:0]     o_completion_data_bus,
  output logic [7:0]       o_completion_dword_keep,
  output sideband_t        o_completion_sideband_word,
  output logic             o_completion_beat_valid,
  input  wire logic        i_completion_beat_ready,
  output logic             o_aer_report
);

  // ==========================================================================
  // Declarations
  logic [1:0]   width_r;
  logic         straddle_r;
  logic         endpoint_r;
  logic         wait_r;
  logic [31:0]  rdata_r;
  logic [31:0]  pkt_cnt_r;
  logic [31:0]  abort_cnt_r;
  logic         aer_r;
  chunk_t       lo_r;
  logic         have_lo_r;
  logic         pay_seen_r;
  logic         ready_r;
  logic         out_valid_r;
  logic [255:0] out_data_r;
  logic [7:0]   out_keep_r;
  sideband_t    out_sb_r;
  logic         straddle_on;
  logic         lo_closes;
  logic         pair_ok;
  logic         fire;
  logic         emit_lo;
  logic         emit_pair;
  logic         emit;
  logic         lo_load;
  logic         have_lo_nxt;
  logic         out_valid_nxt;
  chunk_t       lo_nxt;
  logic         ready_nxt;
  logic         pay_seen_nxt;
  logic [31:0]  lane_mask;
  logic [7:0]   keep_mask;
  chunk_t       slot_b;
  logic         b_on;
  logic [255:0] beat_data;
  logic [7:0]   beat_keep;
  sideband_t    beat_sb;
  logic [31:0]  beat_par;
  logic         first_pay;
  logic         handshake;

  // ==========================================================================
  // Helpers
  // Contiguous byte run for one chunk; descriptor bytes sit below pl_first
  // RULE_02 contiguous payload run
  function automatic logic [15:0] byte_run(input chunk_t c);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < CHUNK_B; i++) begin
      m[i] = c.pl_en && (4'(i) >= c.pl_first) && (4'(i) <= c.pl_last);
    end
    return m;
  endfunction

  // Dword keep bits for the dwords a chunk fills from lane 0
  function automatic logic [3:0] dw_mask(input logic [2:0] cnt);
    logic [4:0] m;
    m = (5'h01 << cnt) - 5'h01;
    return m[3:0];
  endfunction

  // A held chunk closes its beat alone on narrow paths, or at packet end unless a second packet may follow
  function automatic logic closes(input chunk_t c, input logic [1:0] w,
                                  input logic strad);
    return (w != WIDTH_256) || (c.eop && !(strad && c.sop && !c.err));
  endfunction

  // ==========================================================================
  // Register bus: one wait state, action at the edge waitrequest is low
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      wait_r <= 1'h1;
    end else if (!wait_r) begin
      wait_r <= 1'h1;
    end else if (i_avs_read || i_avs_write) begin
      wait_r <= 1'h0;
    end
  end

  // Read data is loaded on the first request cycle and stands while low
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else if (wait_r && i_avs_read) begin
      unique case (i_avs_address)
        REG_CTRL:      rdata_r <= {28'h000_0000, endpoint_r, straddle_r,
                                   width_r};
        REG_STATUS:    rdata_r <= {29'h0000_0000, ready_r, out_valid_r,
                                   have_lo_r};
        REG_PKT_CNT:   rdata_r <= pkt_cnt_r;
        REG_ABORT_CNT: rdata_r <= abort_cnt_r;
        default:       rdata_r <= UNMAPPED_READ;
      endcase
    end
  end

  // Control register; changing mode is only safe with the stream idle
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      width_r    <= CTRL_RESET[CTRL_WIDTH_LSB +: 2];
      straddle_r <= CTRL_RESET[CTRL_STRADDLE_BIT];
      endpoint_r <= CTRL_RESET[CTRL_ENDPOINT_BIT];
    end else if (!wait_r && i_avs_write && i_avs_byteenable[0] &&
                 i_avs_address == REG_CTRL) begin
      width_r    <= i_avs_writedata[CTRL_WIDTH_LSB +: 2];
      straddle_r <= i_avs_writedata[CTRL_STRADDLE_BIT];
      endpoint_r <= i_avs_writedata[CTRL_ENDPOINT_BIT];
    end
  end

  // ==========================================================================
  // Beat assembly control
  always_comb begin
    // RULE_19 straddle only 256
    straddle_on = straddle_r && (width_r == WIDTH_256);
    lo_closes   = closes(lo_r, width_r, straddle_on);
    fire        = i_chunk_valid && ready_r;
    // RULE_14 second packet never aborts
    pair_ok     = !(lo_r.eop && i_chunk.eop && i_chunk.err);
    emit_pair   = have_lo_r && fire && !lo_closes && pair_ok;
    emit_lo     = have_lo_r && !out_valid_r &&
                  (lo_closes || (fire && !pair_ok));
    emit        = emit_lo || emit_pair;
    lo_load     = fire && !emit_pair;
    lo_nxt      = lo_load ? i_chunk : lo_r;
    if (lo_load) begin
      have_lo_nxt = 1'h1;
    end else if (emit) begin
      have_lo_nxt = 1'h0;
    end else begin
      have_lo_nxt = have_lo_r;
    end
    // RULE_21 held until ready
    if (emit) begin
      out_valid_nxt = 1'h1;
    end else if (out_valid_r && i_completion_beat_ready) begin
      out_valid_nxt = 1'h0;
    end else begin
      out_valid_nxt = out_valid_r;
    end
    // Ready is predicted from next state so it can come from a flip-flop
    ready_nxt = !have_lo_nxt ||
                (!closes(lo_nxt, width_r, straddle_on) && !out_valid_nxt);
  end

  // Width masks for flags, parity and keep
  always_comb begin
    unique case (width_r)
      WIDTH_64: begin
        lane_mask = LANE_MASK_64;
        keep_mask = KEEP_MASK_64;
      end
      WIDTH_128: begin
        lane_mask = LANE_MASK_128;
        keep_mask = KEEP_MASK_128;
      end
      default: begin
        lane_mask = LANE_MASK_256;
        keep_mask = KEEP_MASK_256;
      end
    endcase
  end

  // ==========================================================================
  // Beat contents from held lower chunk and optional upper chunk
  always_comb begin
    slot_b    = i_chunk;
    b_on      = emit_pair;
    beat_data = {b_on ? slot_b.data : 128'h0, lo_r.data};
    // RULE_01 payload bytes only
    // RULE_03 narrow paths masked
    // RULE_04 zero length flagged
    beat_sb.byte_en = {b_on ? byte_run(slot_b) : 16'h0000, byte_run(lo_r)}
                      & lane_mask;
    // RULE_20 straddle keeps all
    if (straddle_on) begin
      beat_keep = KEEP_MASK_256;
    end else begin
      beat_keep = {b_on ? dw_mask(slot_b.dw_cnt) : 4'h0,
                   dw_mask(lo_r.dw_cnt)} & keep_mask;
    end
    // RULE_05 first start flag
    // RULE_06 start at lane 0
    beat_sb.first_start_flag  = lo_r.sop;
    // RULE_07 second start lane 16
    // RULE_15 not after abort
    beat_sb.second_start_flag = straddle_on && b_on && lo_r.eop &&
                                slot_b.sop;
    beat_sb.first_end_field  = 4'h0;
    beat_sb.second_end_field = 4'h0;
    // RULE_11 reserved otherwise
    // RULE_22 zero when not straddling
    if (straddle_on) begin
      // RULE_08 first end offset
      if (lo_r.eop) begin
        beat_sb.first_end_field = {3'(lo_r.dw_cnt - 3'h1), 1'h1};
      end else if (b_on && slot_b.eop) begin
        beat_sb.first_end_field = {3'(3'h3 + slot_b.dw_cnt), 1'h1};
      end
      // RULE_09 second end offset
      // RULE_10 implies both flags
      if (b_on && lo_r.eop && slot_b.sop && slot_b.eop) begin
        beat_sb.second_end_field = {3'(3'h3 + slot_b.dw_cnt), 1'h1};
      end
    end
    // Payload seen by the first packet ending in this beat
    first_pay = (lo_r.sop ? 1'h0 : pay_seen_r) | lo_r.pl_en;
    // RULE_12 abort on error
    // RULE_14 payload, last beat
    if (lo_r.eop) begin
      beat_sb.abort = lo_r.err && first_pay;
    end else begin
      beat_sb.abort = b_on && slot_b.eop && slot_b.err &&
                      (first_pay || slot_b.pl_en);
    end
    beat_sb.parity = beat_par;
    // Payload state carried by the packet left open at beat end
    if (b_on && !slot_b.eop) begin
      pay_seen_nxt = slot_b.sop ? slot_b.pl_en :
                     (first_pay || slot_b.pl_en);
    end else begin
      pay_seen_nxt = lo_r.eop ? 1'h0 : first_pay;
    end
  end

  // RULE_17 odd byte parity
  // RULE_18 unused parity zero
  odd_parity_lanes #(
    .LANES (LANES)
  ) u_parity (
    .i_data    (beat_data),
    .i_lane_en (lane_mask),
    .o_parity  (beat_par)
  );

  // ==========================================================================
  // Assembly state
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      have_lo_r  <= 1'h0;
      lo_r       <= '0;
      ready_r    <= 1'h0;
      pay_seen_r <= 1'h0;
    end else begin
      have_lo_r <= have_lo_nxt;
      lo_r      <= lo_nxt;
      ready_r   <= ready_nxt;
      if (emit) begin
        pay_seen_r <= pay_seen_nxt;
      end
    end
  end

  // RULE_21 output held stable
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      out_valid_r <= 1'h0;
      out_data_r  <= '0;
      out_keep_r  <= 8'h00;
      out_sb_r    <= '0;
    end else begin
      out_valid_r <= out_valid_nxt;
      if (emit) begin
        out_data_r <= beat_data;
        out_keep_r <= beat_keep;
        out_sb_r   <= beat_sb;
      end
    end
  end

  // ==========================================================================
  // Statistics and error report, counted when a beat is taken
  assign handshake = out_valid_r && i_completion_beat_ready;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      pkt_cnt_r   <= 32'h0000_0000;
      abort_cnt_r <= 32'h0000_0000;
    end else if (handshake) begin
      pkt_cnt_r   <= pkt_cnt_r + 32'(out_sb_r.first_start_flag) +
                     32'(out_sb_r.second_start_flag);
      abort_cnt_r <= abort_cnt_r + 32'(out_sb_r.abort);
    end
  end

  // RULE_16 endpoint error report
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      aer_r <= 1'h0;
    end else begin
      aer_r <= handshake && out_sb_r.abort && endpoint_r;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops
  assign o_avs_readdata             = rdata_r;
  assign o_avs_waitrequest          = wait_r;
  assign o_chunk_ready              = ready_r;
  assign o_completion_data_bus      = out_data_r;
  assign o_completion_dword_keep    = out_keep_r;
  assign o_completion_sideband_word = out_sb_r;
  assign o_completion_beat_valid    = out_valid_r;
  assign o_aer_report               = aer_r;

endmodule

// ### verification/completion_sideband_framer_checker.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for the completion sideband framer
module completion_sideband_framer_checker
  import cpl_sideband_pkg::*;
(
  input wire logic         i_clock,
  input wire logic         i_rst_b,
  input wire logic         i_avs_read,
  input wire logic         i_avs_write,
  input wire logic         o_avs_waitrequest,
  input wire logic [255:0] o_completion_data_bus,
  input wire sideband_t    o_completion_sideband_word,
  input wire logic         o_completion_beat_valid,
  input wire logic         i_completion_beat_ready,
  input wire logic         o_aer_report
);
  sideband_t s;
  logic      v;
  logic      t;
  logic      ta;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // Short aliases
  assign s = o_completion_sideband_word;
  assign v = o_completion_beat_valid;
  assign t = v && i_completion_beat_ready;
  // Aborted beat taken, kept as one signal for the report check
  assign ta = t && s.abort;

  // Lower eight lanes carry parity in every width
  function automatic logic [7:0] par8(logic [255:0] d);
    for (int i = 0; i < 8; i++) par8[i] = ~^d[8*i +: 8];
  endfunction

  // Adding the lowest set bit clears a single run
  function automatic logic one_run(logic [31:0] b);
    return ((b + (b & -b)) & b) == 32'h0000_0000;
  endfunction

  hold_a: assert property (v && !i_completion_beat_ready |=>
    v && $stable(s) && $stable(o_completion_data_bus))
    else $error("beat changed while stalled");
  par_a: assert property (
    v |-> s.parity[7:0] == par8(o_completion_data_bus))
    else $error("parity wrong");
  run_a: assert property (
    v && !s.second_start_flag |-> one_run(s.byte_en))
    else $error("byte flags not one run");
  end_two_a: assert property (v && s.second_end_field[0] |->
    s.first_end_field[0] && s.second_start_flag)
    else $error("second end without first end");
  off_two_a: assert property (
    v && s.second_end_field[0] |-> s.second_end_field[3:2] == 2'b11)
    else $error("second end offset out of range");
  sof_two_a: assert property (v && s.second_start_flag |->
    s.first_end_field[0] && !s.abort)
    else $error("second start misplaced");
  abort_pl_a: assert property (
    v && s.abort |-> s.byte_en != 32'h0000_0000)
    else $error("abort without payload");
  aer_src_a: assert property (o_aer_report |-> $past(ta))
    else $error("error report without aborted beat");
  wait_one_a: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus wait not one cycle");

  cover property (t && s.abort);
  cover property (t && s.second_start_flag);
  cover property (v && !i_completion_beat_ready ##1 t);
endmodule

bind completion_sideband_framer completion_sideband_framer_checker u_chk (
  .i_clock, .i_rst_b, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
  .o_completion_data_bus, .o_completion_sideband_word,
  .o_completion_beat_valid, .i_completion_beat_ready, .o_aer_report);

// ### verification/completion_receiver_model.sv
`timescale 1ns/10ps
// ==========================================================
// Receiving application logic with random back-pressure
module completion_receiver_model
  import cpl_sideband_pkg::*;
(
  input  wire logic      i_clock,
  input  wire logic      i_rst_b,
  input  wire logic      i_slow,
  input  wire logic      i_valid,
  input  wire sideband_t i_sb,
  output logic           o_ready = 1'b0,
  output int             o_starts,
  output int             o_kept
);
  int seed = 9316;
  // Random stalls force the framer to hold its beat
  always @(posedge i_clock) begin
    o_ready <= i_rst_b && (!i_slow || $random(seed) % 2 == 0);
  end
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_starts <= 0;
      o_kept   <= 0;
    end else if (i_valid && o_ready) begin
      o_starts <= o_starts + i_sb.first_start_flag + i_sb.second_start_flag;
      o_kept   <= o_kept + i_sb.first_start_flag + i_sb.second_start_flag
                  - i_sb.abort;
    end
  end
endmodule

// ### verification/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
// ==========================================================
// Self-checking bench for the completion sideband framer
module tb_top
  import cpl_sideband_pkg::*;
;
  logic         clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0;
  logic         cv = 1'b0, slow = 1'b0, endp = 1'b1, strad = 1'b0;
  logic [3:0]   adr = 4'h0, be = 4'hF;
  logic [31:0]  wdat = 32'h0000_0000, rdat;
  chunk_t       ck = '0;
  logic         wreq, crdy, bv, brdy, aer;
  logic [255:0] dbus;
  logic [7:0]   keep;
  sideband_t    sb;
  logic [1:0]   width = 2'h2;
  int           starts, kept, exp_pk = 0, exp_ab = 0, seed = 9316;
  int           miscompares = 0, n_checks = 0;

  always #20 clk = ~clk;

  completion_sideband_framer u_completion_sideband_framer (
    .i_clock(clk), .i_rst_b(rst_b), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_chunk(ck), .i_chunk_valid(cv),
    .o_chunk_ready(crdy), .o_completion_data_bus(dbus),
    .o_completion_dword_keep(keep), .o_completion_sideband_word(sb),
    .o_completion_beat_valid(bv), .i_completion_beat_ready(brdy),
    .o_aer_report(aer));
  completion_receiver_model u_completion_receiver_model (
    .i_clock(clk), .i_rst_b(rst_b), .i_slow(slow), .i_valid(bv),
    .i_sb(sb), .o_ready(brdy), .o_starts(starts), .o_kept(kept));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A wait that runs out ends the run at once
  task automatic give_up();
    miscompares++;
    $display("[ERR] %0t wait ran out", $time);
    report_and_stop();
  endtask

  // Bus access held until waitrequest is sampled low
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    wr   <= w;
    rd   <= !w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0) give_up();
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic send(input chunk_t c);
    int n = 0;
    @(posedge clk);
    ck <= c;
    cv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (crdy !== 1'b1 && n < 200);
    if (crdy !== 1'b1) give_up();
    cv <= 1'b0;
  endtask

  function automatic logic [31:0] run(chunk_t c, int b);
    logic [31:0] r = '0;
    if (c.pl_en)
      for (int i = c.pl_first; i <= c.pl_last; i++) r[b+i] = 1'b1;
    return r;
  endfunction
  function automatic logic [31:0] par(logic [255:0] d);
    for (int i = 0; i < 32; i++) par[i] = ~^d[8*i +: 8];
  endfunction
  function automatic logic [255:0] xd(chunk_t a, chunk_t b, logic t);
    return t ? {b.data, a.data} : {128'h0, a.data};
  endfunction
  // Expected sideband; straddled pair puts b in lanes 16 up
  function automatic sideband_t xs(chunk_t a, chunk_t b, logic t);
    sideband_t   e = '0;
    logic [31:0] m;
    m = width == 2'h0 ? LANE_MASK_64 : width == 2'h1 ? LANE_MASK_128 : '1;
    e.byte_en = (run(a, 0) | (t ? run(b, 16) : 32'h0000_0000)) & m;
    e.first_start_flag = 1'b1;
    e.second_start_flag = t;
    e.first_end_field = strad ? {a.dw_cnt - 3'd1, 1'b1} : 4'h0;
    e.second_end_field = t ? {b.dw_cnt + 3'd3, 1'b1} : 4'h0;
    e.abort = a.err;
    e.parity = par(xd(a, b, t)) & m;
    return e;
  endfunction

  // Takes one beat on the handshake and compares it
  task automatic beat(input chunk_t a, input chunk_t b, input logic t);
    sideband_t  e;
    logic [7:0] k;
    int         n = 0;
    e = xs(a, b, t);
    k = width == 2'h0 ? KEEP_MASK_64 : width == 2'h1 ? KEEP_MASK_128 : '1;
    k = strad ? 8'hFF : k & ((8'h01 << a.dw_cnt) - 8'h01);
    // Unknown handshake counts as no handshake, so it cannot slip through
    do begin
      @(posedge clk);
      n++;
    end while ((bv && brdy) !== 1'b1 && n < 200);
    if ((bv && brdy) !== 1'b1) give_up();
    `CHK(sb.byte_en, e.byte_en)
    `CHK(sb.parity, e.parity)
    `CHK(sb[33:32], e[33:32])
    `CHK(sb[41:34], e[41:34])
    `CHK(sb.abort, e.abort)
    `CHK(keep, k)
    `CHK(dbus, xd(a, b, t))
    exp_pk += e.first_start_flag + e.second_start_flag;
    exp_ab += e.abort;
    @(posedge clk);
    `CHK(aer, e.abort & endp)
  endtask

  // Random single-chunk packet of at least lo dwords
  function automatic chunk_t rnd(input logic er, input int lo);
    chunk_t c;
    int     nb;
    c.data = {$random(seed), $random(seed), $random(seed), $random(seed)};
    if (width == 2'h0) c.data[127:64] = '0;
    c.dw_cnt = 3'(lo + $unsigned($random(seed))
                  % ((width == 2'h0 ? 3 : 5) - lo));
    nb = 4 * c.dw_cnt;
    c.sop = 1'b1;
    c.eop = 1'b1;
    c.err = er;
    c.pl_en = er | 1'($random(seed));
    c.pl_first = 4'($unsigned($random(seed)) % nb);
    c.pl_last = 4'(c.pl_first + $unsigned($random(seed)) % (nb - c.pl_first));
    return c;
  endfunction

  initial begin
    chunk_t      a, b;
    logic [31:0] q;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    av(1'b0, REG_CTRL, 32'h0000_0000, q);
    `CHK(q, CTRL_RESET)
    be <= 4'hE;
    av(1'b1, REG_CTRL, 32'h0000_0001, q);
    be <= 4'hF;
    av(1'b1, 4'h2, 32'hFFFF_FFFF, q);
    av(1'b0, 4'h2, 32'h0000_0000, q);
    `CHK(q, UNMAPPED_READ)
    av(1'b0, REG_CTRL, 32'h0000_0000, q);
    `CHK(q, CTRL_RESET)
    // Every width; straddle, endpoint and stall each switched on in some passes
    for (int m = 0; m < 12; m++) begin
      width = 2'(m % 3);
      strad = width == 2'h2 && m > 5;
      endp = m[2];
      slow <= m[1];
      av(1'b1, REG_CTRL, {28'h000_0000, endp, strad, width}, q);
      a = rnd(m % 4 == 3, 1);
      if (!strad || a.err) fork send(a); beat(a, a, 1'b0); join
      if (strad) begin
        a = rnd(1'b0, 1);
        b = rnd(1'b0, 3);
        fork begin send(a); send(b); end beat(a, b, 1'b1); join
        b = rnd(1'b1, 1);
        fork begin send(a); send(b); end
          begin beat(a, a, 1'b0); beat(b, b, 1'b0); end join
      end
    end
    av(1'b0, REG_PKT_CNT, 32'h0000_0000, q);
    `CHK(q, 32'(exp_pk))
    av(1'b0, REG_ABORT_CNT, 32'h0000_0000, q);
    `CHK(q, 32'(exp_ab))
    // Idle status: ready high, no beat out, nothing held
    av(1'b0, REG_STATUS, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0004)
    `CHK(starts, exp_pk)
    `CHK(kept, exp_pk - exp_ab)
    report_and_stop();
  end
endmodule
